/* File: include/usc3_pkg.sv */
// Shared constants for the status-two / control-three serial port logic
`default_nettype none
package usc3_pkg;
  // Register offsets on the plain register port
  localparam int unsigned ADDR_W = 2;
  localparam logic [1:0] OFF_STATUS_ONE = 2'h0;
  localparam logic [1:0] OFF_STATUS_TWO = 2'h1;
  localparam logic [1:0] OFF_CONTROL_THREE = 2'h2;
  localparam logic [1:0] OFF_DATA = 2'h3;
  // Field positions, serial_status_two
  localparam int unsigned S2_LIN_BREAK = 7;
  localparam int unsigned S2_RX_EDGE = 6;
  localparam int unsigned S2_RX_INV = 4;
  localparam int unsigned S2_WAKE_IDLE = 3;
  localparam int unsigned S2_LONG_BRK = 2;
  localparam int unsigned S2_LONG_DET = 1;
  // Field positions, serial_control_three
  localparam int unsigned C3_NINTH_TX = 6;
  localparam int unsigned C3_TX_DIR = 5;
  localparam int unsigned C3_TX_INV = 4;
  // Values after reset
  localparam logic [7:0] S2_RESET = 8'h00;
  localparam logic [7:0] C3_RESET = 8'h00;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  // Bit-time counts for break generation and detection
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] BRK_TX_SHORT = 4'hA;
  localparam logic [CNT_W-1:0] BRK_TX_LONG = 4'hD;
  localparam logic [CNT_W-1:0] BRK_RX_SHORT = 4'hA;
  localparam logic [CNT_W-1:0] BRK_RX_LONG = 4'hB;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BREAK = 1'b1
  } usc3_tx_e;
endpackage
`default_nettype wire

/* File: include/usc3_cnt_if.sv */
// Interface between a bit-time counter and its owner
`default_nettype none
interface usc3_cnt_if
  import usc3_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
);
  logic clear;
  logic tick;
  logic [WIDTH-1:0] count;
  modport owner (output clear, output tick, input count);
  modport counter (input clear, input tick, output count);
endinterface
`default_nettype wire

/* File: design/usc3_bit_counter.sv */
// Bit-time counter with synchronous clear
`default_nettype none
module usc3_bit_counter
  import usc3_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic clk,
  input wire logic reset_n,
  usc3_cnt_if.counter cnt
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  assign count_next = cnt.clear ? '0 : (cnt.tick ? count_reg + 1'b1 : count_reg);
  assign cnt.count = count_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

/* File: design/usc3_top.sv */
// Status-two and control-three logic of the asynchronous serial port
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module usc3_top
  import usc3_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic bitTick,
  input wire logic nineBitMode,
  input wire logic rxStandby,
  input wire logic loopModeSelect,
  input wire logic rxSourceSelect,
  input wire logic breakRequest,
  input wire logic serialInPin,
  input wire logic serialOutPinIn,
  output logic serialOutPinOut,
  output logic serialOutPinOe,
  output logic rxLine,
  input wire logic rxStartValid,
  input wire logic rxIdleSeen,
  input wire logic rxCharDone,
  input wire logic [8:0] rxCharData,
  input wire logic rxStopBit,
  input wire logic rxNoise,
  input wire logic rxParityBad,
  input wire logic txShiftOut,
  output logic [8:0] txWord,
  output logic txLoad,
  output logic txBreakActive,
  output logic rxBreakDetect,
  output logic errIrq
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic rx_polarity_flip_reg, wakeIdleSel_reg, longBreakSel_reg, longBreakDet_reg;
  logic linBreakFlag_reg, rxEdgeFlag_reg, rxActive_reg;
  logic ninthTx_reg, singleWireDir_reg, tx_polarity_flip_reg;
  logic [3:0] irqEn_reg;
  logic rxFull_reg, idleFlag_reg, overrun_reg, noise_reg, framing_reg, parity_reg;
  logic [8:0] rxBuf_reg;
  logic s1Armed_reg, idleArm_reg, rxSrcPrev_reg;
  logic [8:0] txWord_reg;
  logic txLoad_reg, pinOut_reg;
  logic [7:0] rdData_reg;
  usc3_tx_e txState_reg, txState_next;

  logic linBreakFlag_next, rxEdgeFlag_next, rxActive_next;
  logic rxFull_next, idleFlag_next, overrun_next, noise_next, framing_next, parity_next;
  logic s1Armed_next, idleArm_next;
  logic [8:0] rxBuf_next;
  logic [7:0] rdData_next;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic wrS2, wrC3, wrData0, rdS1, rdDataReg;
  assign wrS2 = wrEn && (addr == OFF_STATUS_TWO);
  assign wrC3 = wrEn && (addr == OFF_CONTROL_THREE);
  assign wrData0 = wrEn && (addr == OFF_DATA);
  assign rdS1 = rdEn && (addr == OFF_STATUS_ONE);
  assign rdDataReg = rdEn && (addr == OFF_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  logic singleWire, rxSrc, edgeSeen, breakSeen;
  logic [CNT_W-1:0] breakThr;
  usc3_cnt_if rxCnt ();

  assign singleWire = loopModeSelect && rxSourceSelect;
  assign rxSrc = loopModeSelect ? (rxSourceSelect ? serialOutPinIn : pinOut_reg) : serialInPin;
  assign rxLine = rxSrc ^ rx_polarity_flip_reg;
  // Pin edge toward the active level; a polarity write alone is no edge
  assign edgeSeen = (rxSrcPrev_reg != rxSrc) && (rxSrc == rx_polarity_flip_reg);
  assign breakThr = (longBreakDet_reg ? BRK_RX_LONG : BRK_RX_SHORT)
                    + {{(CNT_W-1){1'b0}}, nineBitMode};
  assign rxCnt.clear = rxLine;
  assign rxCnt.tick = bitTick && !rxLine && (rxCnt.count != breakThr);
  assign breakSeen = rxCnt.tick && (rxCnt.count == breakThr - 1'b1);
  assign rxBreakDetect = breakSeen;

  usc3_bit_counter #(.WIDTH(CNT_W)) rxLowCounter (
    .clk(clk),
    .reset_n(reset_n),
    .cnt(rxCnt.counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive status flags
  logic charAccept, charOverrun, clrS1, idleSet, clrLin, clrEdge;
  // Long detect hides characters; stop-bit check never looks at break length
  assign charAccept = rxCharDone && !rxFull_reg && !longBreakDet_reg;
  assign charOverrun = rxCharDone && rxFull_reg;
  assign clrS1 = rdDataReg && s1Armed_reg;
  assign idleSet = rxIdleSeen && idleArm_reg && (!rxStandby || wakeIdleSel_reg);
  assign clrLin = wrS2 && wrData[S2_LIN_BREAK];
  assign clrEdge = wrS2 && wrData[S2_RX_EDGE];

  assign rxFull_next = charAccept || (rxFull_reg && !clrS1);
  assign framing_next = (charAccept && !rxStopBit) || (framing_reg && !clrS1);
  assign noise_next = (charAccept && rxNoise) || (noise_reg && !clrS1);
  assign parity_next = (charAccept && rxParityBad) || (parity_reg && !clrS1);
  assign overrun_next = charOverrun || (overrun_reg && !clrS1);
  assign idleFlag_next = idleSet || (idleFlag_reg && !clrS1);
  assign idleArm_next = charAccept || (idleArm_reg && !idleSet);
  assign s1Armed_next = rdS1 || (s1Armed_reg && !rdDataReg);
  assign rxBuf_next = charAccept ? {nineBitMode && rxCharData[8], rxCharData[7:0]}
                                 : rxBuf_reg;
  assign linBreakFlag_next = (breakSeen && longBreakDet_reg) || (linBreakFlag_reg && !clrLin);
  assign rxEdgeFlag_next = edgeSeen || (rxEdgeFlag_reg && !clrEdge);
  assign rxActive_next = rxStartValid || (rxActive_reg && !rxIdleSeen);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxFull_reg <= 1'b0;
      framing_reg <= 1'b0;
      noise_reg <= 1'b0;
      parity_reg <= 1'b0;
      overrun_reg <= 1'b0;
      idleFlag_reg <= 1'b0;
      idleArm_reg <= 1'b0;
      s1Armed_reg <= 1'b0;
      rxBuf_reg <= 9'h000;
    end else begin
      rxFull_reg <= rxFull_next;
      framing_reg <= framing_next;
      noise_reg <= noise_next;
      parity_reg <= parity_next;
      overrun_reg <= overrun_next;
      idleFlag_reg <= idleFlag_next;
      idleArm_reg <= idleArm_next;
      s1Armed_reg <= s1Armed_next;
      rxBuf_reg <= rxBuf_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linBreakFlag_reg <= 1'b0;
      rxEdgeFlag_reg <= 1'b0;
      rxActive_reg <= 1'b0;
      rxSrcPrev_reg <= 1'b1;
    end else begin
      linBreakFlag_reg <= linBreakFlag_next;
      rxEdgeFlag_reg <= rxEdgeFlag_next;
      rxActive_reg <= rxActive_next;
      rxSrcPrev_reg <= rxSrc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_polarity_flip_reg <= S2_RESET[S2_RX_INV];
      wakeIdleSel_reg <= S2_RESET[S2_WAKE_IDLE];
      longBreakSel_reg <= S2_RESET[S2_LONG_BRK];
      longBreakDet_reg <= S2_RESET[S2_LONG_DET];
    end else if (wrS2) begin
      rx_polarity_flip_reg <= wrData[S2_RX_INV];
      wakeIdleSel_reg <= wrData[S2_WAKE_IDLE];
      longBreakSel_reg <= wrData[S2_LONG_BRK];
      longBreakDet_reg <= wrData[S2_LONG_DET];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ninthTx_reg <= C3_RESET[C3_NINTH_TX];
      singleWireDir_reg <= C3_RESET[C3_TX_DIR];
      tx_polarity_flip_reg <= C3_RESET[C3_TX_INV];
      irqEn_reg <= IRQ_EN_RESET;
    end else if (wrC3) begin
      ninthTx_reg <= wrData[C3_NINTH_TX];
      singleWireDir_reg <= wrData[C3_TX_DIR];
      tx_polarity_flip_reg <= wrData[C3_TX_INV];
      irqEn_reg <= wrData[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path and break generator
  logic [CNT_W-1:0] breakLen;
  logic breakEnd, txLevel;
  usc3_cnt_if txCnt ();

  assign breakLen = (longBreakSel_reg ? BRK_TX_LONG : BRK_TX_SHORT)
                    + {{(CNT_W-1){1'b0}}, nineBitMode};
  assign breakEnd = (txState_reg == TX_BREAK) && bitTick && (txCnt.count == breakLen - 1'b1);
  assign txCnt.clear = (txState_reg == TX_IDLE) || breakEnd;
  assign txCnt.tick = bitTick;

  usc3_bit_counter #(.WIDTH(CNT_W)) txBreakCounter (
    .clk(clk),
    .reset_n(reset_n),
    .cnt(txCnt.counter)
  );

  always_comb begin
    txState_next = txState_reg;
    unique case (txState_reg)
      TX_IDLE: begin
        if (breakRequest) begin
          txState_next = TX_BREAK;
        end
      end
      TX_BREAK: begin
        if (breakEnd && !breakRequest) begin
          txState_next = TX_IDLE;
        end
      end
    endcase
  end

  assign txBreakActive = (txState_reg == TX_BREAK);
  assign txLevel = txBreakActive ? 1'b0 : txShiftOut;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_reg <= TX_IDLE;
      pinOut_reg <= 1'b1;
      txWord_reg <= 9'h000;
      txLoad_reg <= 1'b0;
    end else begin
      txState_reg <= txState_next;
      pinOut_reg <= txLevel ^ tx_polarity_flip_reg;
      txLoad_reg <= wrData0;
      if (wrData0) begin
        txWord_reg <= {nineBitMode && ninthTx_reg, wrData};
      end
    end
  end

  assign serialOutPinOut = pinOut_reg;
  assign serialOutPinOe = !singleWire || singleWireDir_reg;
  assign txWord = txWord_reg;
  assign txLoad = txLoad_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Error interrupt and read port
  logic [3:0] errFlags;
  logic [7:0] s1View, s2View, c3View;
  assign errFlags = {overrun_reg, noise_reg, framing_reg, parity_reg};
  assign errIrq = |(errFlags & irqEn_reg);
  assign s1View = {2'h0, rxFull_reg, idleFlag_reg, errFlags};
  assign s2View = {linBreakFlag_reg, rxEdgeFlag_reg, 1'b0, rx_polarity_flip_reg, wakeIdleSel_reg,
                   longBreakSel_reg, longBreakDet_reg, rxActive_reg};
  // Ninth bit read before data; data read may let a new character in
  assign c3View = {rxBuf_reg[8], ninthTx_reg, singleWireDir_reg, tx_polarity_flip_reg, irqEn_reg};
  assign rdData_next = !rdEn ? 8'h00 :
                       (addr == OFF_STATUS_ONE) ? s1View :
                       (addr == OFF_STATUS_TWO) ? s2View :
                       (addr == OFF_CONTROL_THREE) ? c3View : rxBuf_reg[7:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [CNT_W-1:0] chkTicks_reg, chkLen_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chkTicks_reg <= '0;
      chkLen_reg <= '0;
    end else if (!txBreakActive && txState_next == TX_BREAK) begin
      chkTicks_reg <= '0;
      chkLen_reg <= breakLen;
    end else if (txBreakActive && bitTick) begin
      chkTicks_reg <= chkTicks_reg + 1'b1;
    end
  end

  chk_lin_flag_set: assert property (
    (breakSeen && longBreakDet_reg) |=> linBreakFlag_reg ##1 (linBreakFlag_reg || $past(clrLin)))
    else $error("lin break flag not set after break");
  chk_edge_flag_set: assert property (
    (!loopModeSelect && !$past(loopModeSelect) &&
     (($fell(serialInPin) && !rx_polarity_flip_reg) || ($rose(serialInPin) && rx_polarity_flip_reg))) |=> rxEdgeFlag_reg)
    else $error("edge flag missed an active edge");
  chk_rx_invert: assert property (
    (!loopModeSelect && $changed(rx_polarity_flip_reg) && $stable(serialInPin)) |-> $changed(rxLine))
    else $error("receive polarity flip had no effect");
  chk_idle_gated: assert property (
    (rxIdleSeen && rxStandby && !wakeIdleSel_reg && !idleFlag_reg) |=> !idleFlag_reg)
    else $error("idle flag set in standby with select clear");
  chk_break_length: assert property (
    $fell(txBreakActive) |-> chkTicks_reg == chkLen_reg)
    else $error("transmitted break length wrong");
  chk_long_det_block: assert property (
    (longBreakDet_reg && !rxFull_reg && !framing_reg && !clrS1) |=> !rxFull_reg && !framing_reg)
    else $error("flags set while long detect enabled");
  chk_active_flag: assert property (
    rxStartValid |=> rxActive_reg)
    else $error("active flag not set on start bit");
  chk_active_clear: assert property (
    (rxIdleSeen && !rxStartValid) |=> !rxActive_reg)
    else $error("active flag not cleared on idle");
  chk_ninth_rx: assert property (
    (charAccept && nineBitMode) |=> c3View[7] == $past(rxCharData[8]))
    else $error("ninth receive bit not presented");
  chk_ninth_tx: assert property (
    (wrData0 && nineBitMode) |=> txLoad && txWord == {$past(ninthTx_reg), $past(wrData)})
    else $error("nine-bit transmit word wrong");
  chk_single_wire: assert property (
    singleWire |-> serialOutPinOe == singleWireDir_reg)
    else $error("single-wire direction wrong");
  chk_tx_invert: assert property (
    ##1 serialOutPinOut == ($past(txLevel) ^ $past(tx_polarity_flip_reg)))
    else $error("transmit polarity wrong");
  chk_err_irq: assert property (
    (overrun_reg && irqEn_reg[3]) || (noise_reg && irqEn_reg[2]) ||
    (framing_reg && irqEn_reg[1]) || (parity_reg && irqEn_reg[0]) |-> errIrq)
    else $error("enabled error flag without interrupt");
  chk_fe_with_full: assert property (
    (rxCharDone && !rxFull_reg && !longBreakDet_reg && !rxStopBit) |=> framing_reg && rxFull_reg)
    else $error("framing error not set with receive full");
endmodule
`default_nettype wire

/* File: dv/usc3_remote_node.sv */
// Remote serial node model on the far side of the port pins
`default_nettype none
module usc3_remote_node (
  input wire logic clk,
  input wire logic serialOutPinOut,
  input wire logic serialOutPinOe,
  output logic serialInPin,
  output logic serialOutPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lineLevel = 1'h1;
  logic wireLevel = 1'h1;
  ////////////////////////////////////////////////////////////
  // Shared wire: the device drives it when enabled, else the node does
  assign serialOutPinIn = serialOutPinOe ? serialOutPinOut : wireLevel;
  assign serialInPin = lineLevel;
  ////////////////////////////////////////////////////////////
  // Line changes right after an edge, then holds for the given cycles
  task automatic drive(input logic v, input int hold);
    @(posedge clk);
    lineLevel <= v;
    wireLevel <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the status-two / control-three logic
`default_nettype none
module tb_top
  import usc3_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'h0;
  logic rdEn = 1'h0;
  logic bitTick = 1'h0;
  logic nineBitMode = 1'h0;
  logic rxStandby = 1'h0;
  logic loopModeSelect = 1'h0;
  logic rxSourceSelect = 1'h0;
  logic breakRequest = 1'h0;
  logic rxStartValid = 1'h0;
  logic rxIdleSeen = 1'h0;
  logic rxCharDone = 1'h0;
  logic [8:0] rxCharData = 9'h000;
  logic rxStopBit = 1'h1;
  logic rxNoise = 1'h0;
  logic rxParityBad = 1'h0;
  logic [7:0] rdData;
  logic [8:0] txWord;
  logic serialInPin, serialOutPinIn, serialOutPinOut, serialOutPinOe, rxLine;
  logic txLoad, txBreakActive, rxBreakDetect, errIrq;
  int errTotal = 0;
  int comparisons = 0;
  int n = 0;
  int hit = 0;
  ////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  usc3_top usc3_top_inst (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .bitTick(bitTick), .nineBitMode(nineBitMode),
    .rxStandby(rxStandby), .loopModeSelect(loopModeSelect), .rxSourceSelect(rxSourceSelect),
    .breakRequest(breakRequest), .serialInPin(serialInPin), .serialOutPinIn(serialOutPinIn),
    .serialOutPinOut(serialOutPinOut), .serialOutPinOe(serialOutPinOe), .rxLine(rxLine),
    .rxStartValid(rxStartValid), .rxIdleSeen(rxIdleSeen), .rxCharDone(rxCharDone),
    .rxCharData(rxCharData), .rxStopBit(rxStopBit), .rxNoise(rxNoise),
    .rxParityBad(rxParityBad), .txShiftOut(1'h1), .txWord(txWord), .txLoad(txLoad),
    .txBreakActive(txBreakActive), .rxBreakDetect(rxBreakDetect), .errIrq(errIrq));
  usc3_remote_node usc3_remote_node_inst (.clk(clk), .serialOutPinOut(serialOutPinOut),
    .serialOutPinOe(serialOutPinOe), .serialInPin(serialInPin),
    .serialOutPinIn(serialOutPinIn));
  ////////////////////////////////////////////////////////////
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'h1;
    @(posedge clk);
    wrEn <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'h1;
    @(posedge clk);
    rdEn <= 1'h0;
    #1;
    ck(rdData, e);
  endtask
  task automatic tick;
    @(posedge clk);
    bitTick <= 1'h1;
    #50;
    if (rxBreakDetect === 1'h1 && hit == 0) begin
      hit = n;
    end
    @(posedge clk);
    bitTick <= 1'h0;
    #1;
  endtask
  task automatic rxChar(input logic [8:0] d, input logic s, input logic nz, input logic p);
    @(posedge clk);
    rxCharData <= d;
    rxStopBit <= s;
    rxNoise <= nz;
    rxParityBad <= p;
    rxCharDone <= 1'h1;
    @(posedge clk);
    rxCharDone <= 1'h0;
  endtask
  task automatic rxEvt(input logic idle);
    @(posedge clk);
    rxIdleSeen <= idle;
    rxStartValid <= !idle;
    @(posedge clk);
    rxIdleSeen <= 1'h0;
    rxStartValid <= 1'h0;
  endtask
  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    errTotal++;
    reportAndStop();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    rd(OFF_STATUS_TWO, S2_RESET);
    rd(OFF_CONTROL_THREE, C3_RESET);
    @(posedge clk);
    #1;
    ck(rdData, 8'h00);
    wr(OFF_STATUS_TWO, 8'h1E);
    rd(OFF_STATUS_TWO, 8'h1E);
    wr(OFF_CONTROL_THREE, 8'h7F);
    rd(OFF_CONTROL_THREE, 8'h7F);
    wr(OFF_STATUS_TWO, 8'h00);
    wr(OFF_CONTROL_THREE, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      nineBitMode <= k[0];
      wr(OFF_STATUS_TWO, {6'h00, k[1], 1'h0});
      usc3_remote_node_inst.drive(1'h0, 4);
      hit = 0;
      for (n = 1; n <= 14; n++) begin
        tick();
      end
      ck(hit, 10 + k[0] + k[1]);
      usc3_remote_node_inst.drive(1'h1, 4);
      rd(OFF_STATUS_TWO, {k[1], 1'h1, 4'h0, k[1], 1'h0});
      wr(OFF_STATUS_TWO, 8'hC0);
      rd(OFF_STATUS_TWO, 8'h00);
    end
    $display("test break detect done");
    wr(OFF_STATUS_TWO, 8'h10);
    ck(rxLine, 1'h0);
    usc3_remote_node_inst.drive(1'h0, 4);
    rd(OFF_STATUS_TWO, 8'h10);
    usc3_remote_node_inst.drive(1'h1, 4);
    rd(OFF_STATUS_TWO, 8'h50);
    wr(OFF_STATUS_TWO, 8'h40);
    rd(OFF_STATUS_TWO, 8'h00);
    $display("test edge flag done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      nineBitMode <= k[0];
      wr(OFF_STATUS_TWO, {5'h00, k[1], 2'h0});
      wr(OFF_CONTROL_THREE, {3'h0, k[0], 4'h0});
      @(posedge clk);
      #1;
      ck(serialOutPinOut, !k[0]);
      @(posedge clk);
      breakRequest <= 1'h1;
      @(posedge clk);
      breakRequest <= 1'h0;
      @(posedge clk);
      #1;
      n = 0;
      while (txBreakActive === 1'h1 && n < 20) begin
        tick();
        n++;
        if (n == 2) begin
          ck(serialOutPinOut, k[0]);
        end
      end
      ck(n, 10 + k[0] + 3 * k[1]);
    end
    wr(OFF_STATUS_TWO, 8'h00);
    $display("test break send done");
    @(posedge clk);
    nineBitMode <= 1'h1;
    wr(OFF_CONTROL_THREE, 8'h40);
    wr(OFF_DATA, 8'hA5);
    ck({txLoad, txWord}, 10'h3A5);
    wr(OFF_DATA, 8'h3C);
    ck({txLoad, txWord}, 10'h33C);
    $display("test data write done");
    rxChar(9'h155, 1'h0, 1'h1, 1'h1);
    rxChar(9'h0AA, 1'h1, 1'h0, 1'h0);
    rd(OFF_STATUS_ONE, 8'h2F);
    rd(OFF_CONTROL_THREE, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CONTROL_THREE, 8'h01 << i);
      ck(errIrq, 1'h1);
    end
    wr(OFF_CONTROL_THREE, 8'h00);
    ck(errIrq, 1'h0);
    wr(OFF_CONTROL_THREE, 8'h0F);
    rd(OFF_STATUS_ONE, 8'h2F);
    rd(OFF_DATA, 8'h55);
    rd(OFF_STATUS_ONE, 8'h00);
    ck(errIrq, 1'h0);
    $display("test errors done");
    wr(OFF_STATUS_TWO, 8'h02);
    rxChar(9'h000, 1'h0, 1'h0, 1'h0);
    rd(OFF_STATUS_ONE, 8'h00);
    wr(OFF_STATUS_TWO, 8'h04);
    rxChar(9'h000, 1'h0, 1'h0, 1'h0);
    rd(OFF_STATUS_ONE, 8'h22);
    rd(OFF_DATA, 8'h00);
    $display("test long detect done");
    @(posedge clk);
    rxStandby <= 1'h1;
    for (int w = 0; w < 2; w++) begin
      wr(OFF_STATUS_TWO, {4'h0, w[0], 3'h0});
      rxChar(9'h011, 1'h1, 1'h0, 1'h0);
      rxEvt(1'h1);
      rd(OFF_STATUS_ONE, {3'h1, w[0], 4'h0});
      rd(OFF_DATA, 8'h11);
    end
    @(posedge clk);
    rxStandby <= 1'h0;
    rxEvt(1'h0);
    rd(OFF_STATUS_TWO, 8'h09);
    rxEvt(1'h1);
    rd(OFF_STATUS_TWO, 8'h08);
    $display("test standby and active done");
    @(posedge clk);
    loopModeSelect <= 1'h1;
    rxSourceSelect <= 1'h1;
    wr(OFF_CONTROL_THREE, 8'h00);
    ck(serialOutPinOe, 1'h0);
    wr(OFF_CONTROL_THREE, 8'h20);
    ck(serialOutPinOe, 1'h1);
    $display("test single wire done");
    reportAndStop();
  end
endmodule
`default_nettype wire
